// ### logic/rie_core.sv
// Purpose: Execute software reset and the three return instructions
// Assumes: One instruction issued per cycle when issue is high and busy low
// Notes: Returns take two cycles; work lands at the end of the first
// How it works
// [RL1] Software reset puts every register and flag back to its master-clear value.
// [RL2] Interrupt return pops the stack and loads the popped top value into the PC.
// [RL3] Interrupt return sets the high or low priority global enable as appropriate.
// [RL4] With the option bit 1 the shadows reload W, flags and bank select, else untouched.
// [RL5] Interrupt return is opcode 0000 0000 0001 000s and takes two cycles.
// [RL6] Returns leave the PC upper and high latches unchanged.
// [RL7] Literal return is opcode 0000 1100 kkkk kkkk and takes two cycles.
// [RL8] Literal return writes its 8-bit literal into W.
// [RL9] Literal return loads the PC from the popped stack top.
// [RL10] Literal return does not touch the PC high latch.
// [RL11] After subroutine return the PC equals the former stack top.
// [RL12] Subroutine return is 0000 0000 0001 001s, two cycles, shadows only when s is 1.
module rie_core
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Instruction issue
   input wire logic issue,
   input wire logic [rie_pkg::OP_W-1:0] opcode,
   input wire logic in_high_irq,
   output logic busy,
   // Stack
   input wire logic [rie_pkg::PC_W-1:0] stack_top_value,
   output logic stack_pop,
   // Shadows
   input wire logic [rie_pkg::DATA_W-1:0] working_shadow,
   input wire logic [rie_pkg::DATA_W-1:0] flags_shadow,
   input wire logic [rie_pkg::BANK_W-1:0] bank_select_shadow,
   // Live state
   output logic [rie_pkg::PC_W-1:0] pc,
   output logic [rie_pkg::DATA_W-1:0] working,
   output logic [rie_pkg::DATA_W-1:0] flags,
   output logic [rie_pkg::BANK_W-1:0] bank_select_register,
   output logic [rie_pkg::DATA_W-1:0] pc_high_latch,
   output logic [rie_pkg::DATA_W-1:0] pc_upper_latch,
   output logic high_priority_global_enable,
   output logic low_priority_global_enable,
   output logic soft_reset_pulse
);
   import rie_pkg::*;

   rie_kind_t kind;
   logic shadow_opt;
   logic sw_reset;
   logic take;
   logic ret_take;
   logic soft_take;
   logic busy_reg, busy_next;
   logic srst_reg, srst_next;
   logic [PC_W-1:0] pc_reg, pc_next;
   logic [DATA_W-1:0] w_reg, w_next;
   logic [DATA_W-1:0] flags_reg, flags_next;
   logic [BANK_W-1:0] bank_reg, bank_next;
   logic gh_reg, gh_next;
   logic gl_reg, gl_next;
   logic [DATA_W-1:0] hi_latch_reg, hi_latch_next;
   logic [DATA_W-1:0] up_latch_reg, up_latch_next;

   rie_decode u_dec
   (
      .opcode(opcode),
      .kind(kind),
      .shadow_opt(shadow_opt),
      .sw_reset(sw_reset)
   );

   assign take = issue && !busy_reg;
   assign ret_take = take && (kind != RIE_NONE);
   assign soft_take = take && sw_reset;
   assign busy = busy_reg;
   assign stack_pop = ret_take; // [RL2]

   // Sequencing: second return cycle, reset pulse
   always_comb
   begin
      busy_next = 1'b0;
      srst_next = 1'b0;
      if (ret_take)
      begin
         busy_next = 1'b1; // [RL5] [RL7] [RL12]
      end
      if (soft_take)
      begin
         srst_next = 1'b1; // [RL1]
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy_reg <= 1'b0;
         srst_reg <= 1'b0;
      end
      else
      begin
         busy_reg <= busy_next;
         srst_reg <= srst_next;
      end
   end

   // Program counter
   always_comb
   begin
      pc_next = pc_reg;
      if (soft_take)
      begin
         pc_next = PC_RESET; // [RL1]
      end
      else if (ret_take)
      begin
         pc_next = stack_top_value; // [RL2] [RL9] [RL11]
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pc_reg <= PC_RESET;
      end
      else
      begin
         pc_reg <= pc_next;
      end
   end

   // Working, flags and bank select
   always_comb
   begin
      w_next = w_reg;
      flags_next = flags_reg;
      bank_next = bank_reg;
      if (soft_take)
      begin
         w_next = W_RESET; // [RL1]
         flags_next = FLAGS_RESET;
         bank_next = BANK_RESET;
      end
      else if (ret_take && kind == RIE_LIT)
      begin
         w_next = opcode[7:0]; // [RL8]
      end
      else if (ret_take && shadow_opt)
      begin
         w_next = working_shadow; // [RL4] [RL12]
         flags_next = flags_shadow;
         bank_next = bank_select_shadow;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         w_reg <= W_RESET;
         flags_reg <= FLAGS_RESET;
         bank_reg <= BANK_RESET;
      end
      else
      begin
         w_reg <= w_next;
         flags_reg <= flags_next;
         bank_reg <= bank_next;
      end
   end

   // Global interrupt enables
   always_comb
   begin
      gh_next = gh_reg;
      gl_next = gl_reg;
      if (soft_take)
      begin
         gh_next = 1'b0; // [RL1]
         gl_next = 1'b0;
      end
      else if (ret_take && kind == RIE_INT)
      begin
         if (in_high_irq)
         begin
            gh_next = 1'b1; // [RL3]
         end
         else
         begin
            gl_next = 1'b1; // [RL3]
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gh_reg <= 1'b0;
         gl_reg <= 1'b0;
      end
      else
      begin
         gh_reg <= gh_next;
         gl_reg <= gl_next;
      end
   end

   // PC latches; no return writes them
   always_comb
   begin
      hi_latch_next = hi_latch_reg; // [RL6] [RL10]
      up_latch_next = up_latch_reg; // [RL6]
      if (soft_take)
      begin
         hi_latch_next = LATCH_RESET; // [RL1]
         up_latch_next = LATCH_RESET;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hi_latch_reg <= LATCH_RESET;
         up_latch_reg <= LATCH_RESET;
      end
      else
      begin
         hi_latch_reg <= hi_latch_next;
         up_latch_reg <= up_latch_next;
      end
   end

   // Outputs
   assign pc_high_latch = hi_latch_reg;
   assign pc_upper_latch = up_latch_reg;
   assign pc = pc_reg;
   assign working = w_reg;
   assign flags = flags_reg;
   assign bank_select_register = bank_reg;
   assign high_priority_global_enable = gh_reg;
   assign low_priority_global_enable = gl_reg;
   assign soft_reset_pulse = srst_reg;
endmodule : rie_core

// ### inc/rie_pkg.sv
// Purpose: Shared constants for the return-instruction execution block
// Assumes: 16-bit opcodes, 21-bit program counter, 8-bit data
// Notes: Reset values follow a master-clear reset of the core
package rie_pkg;
   localparam int OP_W = 16;
   localparam int PC_W = 21;
   localparam int DATA_W = 8;
   localparam int BANK_W = 4;
   localparam logic [15:0] OP_SW_RESET = 16'h00ff;
   localparam logic [14:0] OP_INT_RET_HI = 15'h0008;
   localparam logic [14:0] OP_SUB_RET_HI = 15'h0009;
   localparam logic [7:0] OP_LIT_RET_HI = 8'h0c;
   localparam logic [20:0] PC_RESET = 21'h000000;
   localparam logic [7:0] W_RESET = 8'h00;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [3:0] BANK_RESET = 4'h0;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [1:0] CYCLES_RET = 2'h2;
   typedef enum logic [1:0] {RIE_NONE, RIE_INT, RIE_LIT, RIE_SUB} rie_kind_t;
endpackage : rie_pkg

// ### logic/rie_decode.sv
// Purpose: Classify an opcode into one of the return kinds
// Assumes: Opcode from the fetch latch, same clock
// Notes: Combinational only
module rie_decode
(
   // Opcode in
   input wire logic [rie_pkg::OP_W-1:0] opcode,
   // Classification
   output rie_pkg::rie_kind_t kind,
   output logic shadow_opt,
   output logic sw_reset
);
   import rie_pkg::*;
   always_comb
   begin
      kind = RIE_NONE;
      shadow_opt = opcode[0];
      sw_reset = (opcode == OP_SW_RESET);
      if (opcode[15:1] == OP_INT_RET_HI)
      begin
         kind = RIE_INT; // [RL5]
      end
      else if (opcode[15:1] == OP_SUB_RET_HI)
      begin
         kind = RIE_SUB; // [RL12]
      end
      else if (opcode[15:8] == OP_LIT_RET_HI)
      begin
         kind = RIE_LIT; // [RL7]
      end
   end
endmodule : rie_decode

// ### dv/rie_chk.sv
// Purpose: Port-level checks of the return execution block
// Assumes: Watches rie_core ports only
// Notes: Bound after the module
module rie_chk
   import rie_pkg::*;
(
   // Control
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic issue,
   input wire logic busy,
   input wire logic stack_pop,
   input wire logic in_high_irq,
   input wire logic soft_reset_pulse,
   // Data
   input wire logic [OP_W-1:0] opcode,
   input wire logic [PC_W-1:0] stack_top_value,
   input wire logic [PC_W-1:0] pc,
   input wire logic [DATA_W-1:0] working_shadow,
   input wire logic [DATA_W-1:0] flags_shadow,
   input wire logic [BANK_W-1:0] bank_select_shadow,
   input wire logic [DATA_W-1:0] working,
   input wire logic [DATA_W-1:0] flags,
   input wire logic [BANK_W-1:0] bank_select_register,
   input wire logic [DATA_W-1:0] pc_high_latch,
   input wire logic [DATA_W-1:0] pc_upper_latch,
   input wire logic high_priority_global_enable,
   input wire logic low_priority_global_enable
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire tk = issue && !busy;
   wire is_int = tk && opcode[15:1] == OP_INT_RET_HI;
   wire is_sub = tk && opcode[15:1] == OP_SUB_RET_HI;
   wire is_lit = tk && opcode[15:8] == OP_LIT_RET_HI;
   wire is_shd = (is_int || is_sub) && opcode[0];
   sequence ret_take; is_int || is_sub || is_lit; endsequence
   sequence two_cyc; busy ##1 !busy; endsequence
   pop_load_a: assert property (ret_take |-> stack_pop ##1 pc == $past(stack_top_value))
      else $error("pop or pc load wrong");
   lit_load_a: assert property (is_lit |=> working == $past(opcode[7:0]))
      else $error("literal not in working");
   shadow_load_a: assert property (is_shd |=> working == $past(working_shadow)
      && flags == $past(flags_shadow) && bank_select_register == $past(bank_select_shadow))
      else $error("shadow not restored");
   no_shadow_a: assert property ((is_int || is_sub) && !opcode[0] |=> $stable(working)
      && $stable(flags) && $stable(bank_select_register))
      else $error("registers changed without shadow option");
   high_en_a: assert property (is_int && in_high_irq |=> high_priority_global_enable)
      else $error("high enable not set");
   low_en_a: assert property (is_int && !in_high_irq |=> low_priority_global_enable)
      else $error("low enable not set");
   two_cycle_a: assert property (ret_take |=> two_cyc)
      else $error("return not two cycles");
   latch_hold_a: assert property (pc_high_latch == LATCH_RESET && pc_upper_latch == LATCH_RESET)
      else $error("latch changed");
   soft_rst_a: assert property (tk && opcode == OP_SW_RESET |=> soft_reset_pulse
      && pc == PC_RESET && working == W_RESET && flags == FLAGS_RESET
      && !high_priority_global_enable && !low_priority_global_enable)
      else $error("software reset wrong");
   refuse_pop_a: assert property (busy |-> !stack_pop)
      else $error("pop while busy");
   refuse_keep_a: assert property (busy && issue |=> $stable(pc) && $stable(working))
      else $error("refused issue changed state");
endmodule : rie_chk
bind rie_core rie_chk i_rie_chk (.*);

// ### dv/test_return_instruction_execution.sv
// Purpose: Directed bench for the return execution block
// Assumes: Inputs driven at rising edge
// Notes: Checks at falling edge
module test_return_instruction_execution;
   timeunit 1ns;
   timeprecision 1ns;
   import rie_pkg::*;
   logic clk_sys = 0, rst_n = 0, issue = 0, in_high_irq = 0, busy, stack_pop, soft_reset_pulse;
   logic high_priority_global_enable, low_priority_global_enable;
   logic [OP_W-1:0] opcode = 16'h0000;
   logic [PC_W-1:0] stack_top_value = 21'h000000, pc;
   logic [DATA_W-1:0] working_shadow = 8'h00, flags_shadow = 8'h00, working, flags;
   logic [DATA_W-1:0] pc_high_latch, pc_upper_latch;
   logic [BANK_W-1:0] bank_select_shadow = 4'h0, bank_select_register;
   int n_fail = 0, total_checks = 0;
   rie_core i_rie_core (.*);
   always #50 clk_sys = ~clk_sys;
   task summarize;
      $display("checks %0d fails %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task wait_idle;
      int k;
      for (k = 0; busy !== 1'b0 && k < 4; k++) @(negedge clk_sys);
      if (busy !== 1'b0)
      begin
         n_fail++;
         summarize;
      end
   endtask : wait_idle
   task run(input logic [15:0] op, input logic [20:0] top, input logic hi, input logic pop);
      wait_idle;
      @(posedge clk_sys);
      issue <= 1'b1;
      opcode <= op;
      stack_top_value <= top;
      in_high_irq <= hi;
      @(negedge clk_sys);
      chk(stack_pop, pop);
      @(posedge clk_sys);
      issue <= 1'b0;
      @(negedge clk_sys);
   endtask : run
   task t_lit;
      run(16'h0c5a, 21'h12345, 1'b0, 1'b1);
      chk(pc, 21'h12345);
      chk(working, 8'h5a);
      chk(pc_high_latch, LATCH_RESET);
      chk(busy, 1'b1);
   endtask : t_lit
   task t_refuse;
      wait_idle;
      @(posedge clk_sys);
      issue <= 1'b1;
      opcode <= 16'h0c33;
      stack_top_value <= 21'h00222;
      @(posedge clk_sys);
      opcode <= 16'h0c77;
      stack_top_value <= 21'h00555;
      @(negedge clk_sys);
      chk(stack_pop, 1'b0);
      @(posedge clk_sys);
      issue <= 1'b0;
      @(negedge clk_sys);
      chk({pc, working}, 29'h0022233);
   endtask : t_refuse
   task t_int_shadow;
      @(posedge clk_sys);
      working_shadow <= 8'ha5;
      flags_shadow <= 8'h3c;
      bank_select_shadow <= 4'h9;
      run(16'h0011, 21'h0abcd, 1'b1, 1'b1);
      chk(pc, 21'h0abcd);
      chk({working, flags, bank_select_register}, 20'ha53c9);
      chk(high_priority_global_enable, 1'b1);
      chk(low_priority_global_enable, 1'b0);
      chk(pc_upper_latch, LATCH_RESET);
   endtask : t_int_shadow
   task t_plain;
      @(posedge clk_sys);
      working_shadow <= 8'h11;
      flags_shadow <= 8'h5e;
      bank_select_shadow <= 4'h6;
      run(16'h0012, 21'h1fffe, 1'b0, 1'b1);
      chk({pc, working}, 29'h1fffea5);
      chk(flags, 8'h3c);
      run(16'h0010, 21'h00100, 1'b0, 1'b1);
      chk({working, low_priority_global_enable}, 9'h14b);
      chk(pc, 21'h00100);
      run(16'h0013, 21'h00200, 1'b0, 1'b1);
      chk({working, flags, bank_select_register}, 20'h115e6);
      chk(pc, 21'h00200);
   endtask : t_plain
   task t_sw_reset;
      run(16'h00ff, 21'h00777, 1'b0, 1'b0);
      chk({soft_reset_pulse, pc, working, high_priority_global_enable}, 31'h40000000);
      chk({flags, bank_select_register}, {FLAGS_RESET, BANK_RESET});
      chk({low_priority_global_enable, busy}, 2'h0);
      @(negedge clk_sys);
      chk(soft_reset_pulse, 1'b0);
   endtask : t_sw_reset
   task t_hw_reset;
      run(16'h0011, 21'h00abc, 1'b1, 1'b1);
      chk(working, 8'h11);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      @(negedge clk_sys);
      chk({pc, working}, {PC_RESET, W_RESET});
      chk({flags, bank_select_register}, {FLAGS_RESET, BANK_RESET});
      chk({high_priority_global_enable, low_priority_global_enable, busy}, 3'h0);
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
   endtask : t_hw_reset
   initial
   begin
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_lit;
      t_refuse;
      t_int_shadow;
      t_plain;
      t_sw_reset;
      t_hw_reset;
      t_lit;
      summarize;
   end
endmodule : test_return_instruction_execution
